// ==== verilog/tsched_pkg.sv ====
// Purpose: shared constants for the trigger scheduler
// Assumes: 32-bit APB data, byte addresses
// Notes: all register offsets are byte addresses
package tsched_pkg;
    localparam int NUM_EV = 8;
    localparam int EV_IDX_W = 3;
    localparam int NUM_FIFO = 4;
    localparam int CMD_DEPTH = 24;
    localparam int CMD_AW = 5;
    localparam int CMD_PER_PERIOD = 24;
    localparam int FIFO_AW = 6;
    localparam int FIFO_WORDS = 40;
    localparam int LVL_W = 5;
    localparam int PTR_W = 4;
    localparam int ADDR_W = 12;
    // register offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_EDGE = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_SRC = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h00c;
    localparam logic [ADDR_W-1:0] OFS_MASK = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_LEVEL = 12'h018;
    localparam logic [ADDR_W-1:0] OFS_CMP = 12'h020;
    localparam logic [ADDR_W-1:0] OFS_TCFG = 12'h040;
    localparam logic [ADDR_W-1:0] OFS_FIFO = 12'h060;
    localparam logic [ADDR_W-1:0] OFS_CMD = 12'h080;
    // field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_MODE_BIT = 1;
    localparam int EDGE_RISE_BIT = 0;
    localparam int EDGE_FALL_BIT = 1;
    localparam int ST_W = 10;
    localparam int ST_OVR_BIT = 8;
    localparam int ST_FOVF_BIT = 9;
    localparam int BUSY_BIT = 31;
    localparam int VALID_BIT = 31;
    localparam int LVL_STRIDE = 8;
    localparam int TCFG_W = 12;
    localparam int TC_PULSE_BIT = 0;
    localparam int TC_CMD_BIT = 1;
    localparam int TC_FIRST_LSB = 2;
    localparam int TC_CNT_LSB = 7;
    localparam int CHAN_W = 5;
    localparam int CMD_W = 9;
    localparam int CMD_CONV_BIT = 5;
    localparam int CMD_DUAL_BIT = 6;
    localparam int CMD_FIFO_LSB = 7;

    typedef enum logic [2:0] {
        SQ_IDLE = 3'b000,
        SQ_FETCH = 3'b001,
        SQ_SEND = 3'b010,
        SQ_WAIT = 3'b011,
        SQ_WR0 = 3'b100,
        SQ_WR1 = 3'b101
    } seq_e;

    // two deep fifos of sixteen, two shallow of four
    function automatic int fifo_depth(input int k);
        return (k < 2) ? 16 : 4;
    endfunction : fifo_depth

    function automatic int fifo_base(input int k);
        return (k < 2) ? k * 16 : 32 + (k - 2) * 4;
    endfunction : fifo_base
endpackage : tsched_pkg

// ==== verilog/mem_if.sv ====
// Purpose: write and read port of a small memory
// Assumes: one write and one registered read per cycle
// Notes: read data arrive one cycle after the address
`timescale 1ns/1ps
interface mem_if #(parameter int AW = 5, parameter int DW = 9);
    logic we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;
    modport ctrl (output we, waddr, wdata, raddr, input rdata);
    modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface : mem_if

// ==== verilog/tsched_mem.sv ====
// Purpose: word memory with registered read data
// Assumes: addresses beyond depth are ignored
// Notes: contents are not reset
`timescale 1ns/1ps
module tsched_mem #(
    parameter int DEPTH = 24,
    parameter int AW = 5,
    parameter int DW = 9
) (
    input wire logic ref_clk_i, // clock
    mem_if.mem bus              // memory port
);
    if (DEPTH > (1 << AW)) begin : g_chk
        $error("depth exceeds address range");
    end
    logic [DW-1:0] ram_q [DEPTH];
    always_ff @(posedge ref_clk_i) begin
        if (bus.we && bus.waddr < AW'(DEPTH)) begin
            ram_q[bus.waddr] <= bus.wdata;
        end
        bus.rdata <= (bus.raddr < AW'(DEPTH)) ? ram_q[bus.raddr] : '0;
    end
endmodule : tsched_mem

// ==== verilog/trigger_scheduler.sv ====
// Purpose: event driven counter that schedules triggers and converter commands
// Assumes: converter handshake signals share ref_clk_i; event pins are asynchronous
// Notes: apb slave, every access answers on the third access cycle
// Operation
// - each input selects rising, falling or both edges
// - triggered mode reloads counter on ORed events
// - eight comparators give eight delayed triggers
// - sequential mode: one comparator after any event
// - trigger gives pulse, commands, or both
// - command holds channel, converter, dual flag, fifo
// - four result fifos: two of 16, two of 4
// - dual conversion writes both results one fifo
// - at most 24 commands per control period
// - next command only after conversion completes
// - trigger can raise an interrupt request
`timescale 1ns/1ps
module trigger_scheduler import tsched_pkg::*; #(
    parameter int CNT_W = 16, // counter and delay width
    parameter int RES_W = 12  // converter result width
) (
    input wire logic ref_clk_i,                // 50 MHz clock
    input wire logic rst_i,                    // async reset, high
    input wire logic psel_i,                   // apb select
    input wire logic penable_i,                // apb enable
    input wire logic pwrite_i,                 // apb write
    input wire logic [ADDR_W-1:0] paddr_i,     // apb byte address
    input wire logic [31:0] pwdata_i,          // apb write data
    output logic [31:0] prdata_o,              // apb read data
    output logic pready_o,                     // apb ready
    output logic pslverr_o,                    // apb error
    input wire logic [NUM_EV-1:0] event_i,     // event pins
    input wire logic [1:0] conv_done_i,        // conversion done per converter
    input wire logic [RES_W-1:0] conv0_data_i, // converter 0 result
    input wire logic [RES_W-1:0] conv1_data_i, // converter 1 result
    output logic [NUM_EV-1:0] trig_o,          // trigger pulses
    output logic cmd_valid_o,                  // command strobe
    output logic [CHAN_W-1:0] cmd_chan_o,      // channel to sample
    output logic cmd_conv_o,                   // converter select
    output logic cmd_dual_o,                   // both converters
    output logic irq_o                         // interrupt level
);
    if (CNT_W < 2 || CNT_W > 24 || RES_W < 1 || RES_W > 24) begin : g_chk
        $error("parameter out of range");
    end

    typedef struct packed {
        logic [NUM_EV-1:0] s1;
        logic [NUM_EV-1:0] s2;
        logic [NUM_EV-1:0] s3;
        logic en;
        logic mode;
        logic [2*NUM_EV-1:0] edge_sel;
        logic [NUM_EV-1:0] src;
        logic [NUM_EV-1:0] fired;
        logic [NUM_EV-1:0] trig;
        logic [NUM_EV-1:0][CNT_W-1:0] cmp;
        logic [NUM_EV-1:0][TCFG_W-1:0] tcfg;
        logic [ST_W-1:0] status;
        logic [ST_W-1:0] mask;
        logic [CNT_W-1:0] cnt;
        logic armed;
        logic [EV_IDX_W-1:0] seq_idx;
        seq_e st;
        logic [CMD_AW-1:0] idx;
        logic [CMD_AW-1:0] left;
        logic [CMD_AW-1:0] per_cnt;
        logic [CMD_W-1:0] cur;
        logic [1:0] seen;
        logic [RES_W-1:0] r0;
        logic [RES_W-1:0] r1;
        logic [NUM_FIFO-1:0][PTR_W-1:0] wp;
        logic [NUM_FIFO-1:0][PTR_W-1:0] rp;
        logic [NUM_FIFO-1:0][LVL_W-1:0] lvl;
        logic acc;
        logic avail;
        logic ready;
        logic err;
        logic [31:0] rdata;
        logic cmd_v;
        logic irq;
    } state_s;

    state_s q;
    state_s d;

    mem_if #(.AW(CMD_AW), .DW(CMD_W)) cmd_bus ();
    mem_if #(.AW(FIFO_AW), .DW(RES_W + 1)) fifo_bus ();

    tsched_mem #(.DEPTH(CMD_DEPTH), .AW(CMD_AW), .DW(CMD_W)) u_cmd_mem (
        .ref_clk_i(ref_clk_i),
        .bus(cmd_bus.mem)
    );
    tsched_mem #(.DEPTH(FIFO_WORDS), .AW(FIFO_AW), .DW(RES_W + 1)) u_fifo_mem (
        .ref_clk_i(ref_clk_i),
        .bus(fifo_bus.mem)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // edge detection, one slice per event input
    logic [NUM_EV-1:0] hit;
    for (genvar g = 0; g < NUM_EV; g++) begin : g_edge
        assign hit[g] = (q.edge_sel[2*g+EDGE_RISE_BIT] & q.s2[g] & ~q.s3[g]) |
                        (q.edge_sel[2*g+EDGE_FALL_BIT] & ~q.s2[g] & q.s3[g]);
    end

    function automatic logic [EV_IDX_W-1:0] lowest(input logic [NUM_EV-1:0] v);
        logic [EV_IDX_W-1:0] r;
        r = '0;
        for (int i = NUM_EV - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = EV_IDX_W'(i);
            end
        end
        return r;
    endfunction : lowest

    logic [1:0] fsel;
    assign fsel = paddr_i[3:2];
    assign cmd_bus.raddr = q.idx;
    assign fifo_bus.raddr = FIFO_AW'(fifo_base(int'(fsel))) + FIFO_AW'(q.rp[fsel]);

    ////////////////////////////////////////////////////////////////////////////////
    // next state
    logic reload;
    logic [NUM_EV-1:0] fire;
    logic [NUM_EV-1:0] cmd_req;
    logic [ST_W-1:0] st_set;
    logic [ST_W-1:0] st_clr;
    logic push;
    logic [1:0] push_f;
    logic [RES_W:0] push_data;
    logic pop;
    logic [NUM_EV-1:0] pulse_en;
    logic [1:0] need;
    logic [1:0] seen_n;

    always_comb begin
        logic [31:0] rv;
        logic [EV_IDX_W-1:0] ri;
        logic [EV_IDX_W-1:0] li;
        rv = '0;
        ri = paddr_i[4:2];
        li = '0;
        d = q;
        st_set = '0;
        st_clr = '0;
        push = 1'b0;
        push_f = q.cur[CMD_FIFO_LSB +: 2];
        push_data = '0;
        pop = 1'b0;
        need = '0;
        seen_n = '0;
        cmd_bus.we = 1'b0;
        cmd_bus.waddr = paddr_i[CMD_AW+1:2];
        cmd_bus.wdata = pwdata_i[CMD_W-1:0];
        fifo_bus.we = 1'b0;
        fifo_bus.waddr = '0;
        fifo_bus.wdata = '0;
        d.s1 = event_i;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.trig = '0;
        d.cmd_v = 1'b0;
        fire = '0;
        for (int i = 0; i < NUM_EV; i++) begin
            pulse_en[i] = q.tcfg[i][TC_PULSE_BIT];
            cmd_req[i] = 1'b0;
        end

        // counter and comparators
        reload = q.en & (q.mode ? (hit[0] & q.src[0]) : |(hit & q.src));
        if (q.cnt != '1) begin
            d.cnt = q.cnt + 1'b1;
        end
        if (q.en && !q.mode) begin
            for (int i = 0; i < NUM_EV; i++) begin
                fire[i] = !reload && !q.fired[i] && q.cnt == q.cmp[i];
            end
            d.fired = q.fired | fire;
            if (reload) begin
                d.cnt = '0;
                d.fired = '0;
            end
        end else if (q.en && q.mode) begin
            if (q.armed && q.cnt == q.cmp[0]) begin
                fire[q.seq_idx] = 1'b1;
                d.armed = 1'b0;
            end
            if (|(hit & q.src)) begin
                d.cnt = '0;
                d.seq_idx = lowest(hit & q.src);
                d.armed = 1'b1;
            end
        end
        if (reload) begin
            d.per_cnt = '0;
        end
        d.trig = fire & pulse_en;
        st_set[NUM_EV-1:0] = fire;
        for (int i = 0; i < NUM_EV; i++) begin
            cmd_req[i] = fire[i] & q.tcfg[i][TC_CMD_BIT];
        end

        // command sequencer
        if (|cmd_req) begin
            li = lowest(cmd_req);
            if (q.st != SQ_IDLE || (cmd_req & (cmd_req - 1'b1)) != '0) begin
                st_set[ST_OVR_BIT] = 1'b1;
            end
        end
        need = q.cur[CMD_DUAL_BIT] ? 2'b11 : (q.cur[CMD_CONV_BIT] ? 2'b10 : 2'b01);
        seen_n = q.seen | conv_done_i;
        case (q.st)
            SQ_IDLE: begin
                if (|cmd_req && q.tcfg[li][TC_CNT_LSB +: CMD_AW] != '0) begin
                    d.idx = q.tcfg[li][TC_FIRST_LSB +: CMD_AW];
                    d.left = q.tcfg[li][TC_CNT_LSB +: CMD_AW];
                    d.st = SQ_FETCH;
                end
            end
            SQ_FETCH: begin
                d.st = SQ_SEND;
            end
            SQ_SEND: begin
                if (int'(q.per_cnt) >= CMD_PER_PERIOD) begin
                    st_set[ST_OVR_BIT] = 1'b1;
                    d.st = SQ_IDLE;
                end else begin
                    d.cur = cmd_bus.rdata;
                    d.cmd_v = 1'b1;
                    d.seen = '0;
                    d.per_cnt = q.per_cnt + 1'b1;
                    d.st = SQ_WAIT;
                end
            end
            SQ_WAIT: begin
                d.seen = seen_n;
                if (conv_done_i[0]) begin
                    d.r0 = conv0_data_i;
                end
                if (conv_done_i[1]) begin
                    d.r1 = conv1_data_i;
                end
                if ((seen_n & need) == need) begin
                    d.st = SQ_WR0;
                end
            end
            SQ_WR0: begin
                push = 1'b1;
                push_data = (q.cur[CMD_CONV_BIT] && !q.cur[CMD_DUAL_BIT]) ? {1'b1, q.r1} : {1'b0, q.r0};
                if (q.cur[CMD_DUAL_BIT]) begin
                    d.st = SQ_WR1;
                end
            end
            SQ_WR1: begin
                push = 1'b1;
                push_data = {1'b1, q.r1};
            end
            default: begin
                d.st = SQ_IDLE;
            end
        endcase
        if ((q.st == SQ_WR0 && !q.cur[CMD_DUAL_BIT]) || q.st == SQ_WR1) begin
            d.left = q.left - 1'b1;
            d.idx = (int'(q.idx) == CMD_DEPTH - 1) ? '0 : q.idx + 1'b1;
            d.st = (q.left == CMD_AW'(1)) ? SQ_IDLE : SQ_FETCH;
        end

        // apb slave
        d.ready = 1'b0;
        d.err = 1'b0;
        if (psel_i && penable_i && !q.acc && !q.ready) begin
            d.acc = 1'b1;
            d.avail = q.lvl[fsel] != '0;
        end
        if (q.acc) begin
            d.acc = 1'b0;
            d.ready = 1'b1;
            if (paddr_i == OFS_CTRL) begin
                rv[CTRL_EN_BIT] = q.en;
                rv[CTRL_MODE_BIT] = q.mode;
                if (pwrite_i) begin
                    d.en = pwdata_i[CTRL_EN_BIT];
                    d.mode = pwdata_i[CTRL_MODE_BIT];
                end
            end else if (paddr_i == OFS_EDGE) begin
                rv[2*NUM_EV-1:0] = q.edge_sel;
                if (pwrite_i) begin
                    d.edge_sel = pwdata_i[2*NUM_EV-1:0];
                end
            end else if (paddr_i == OFS_SRC) begin
                rv[NUM_EV-1:0] = q.src;
                if (pwrite_i) begin
                    d.src = pwdata_i[NUM_EV-1:0];
                end
            end else if (paddr_i == OFS_STATUS) begin
                rv[ST_W-1:0] = q.status;
                if (pwrite_i) begin
                    st_clr = pwdata_i[ST_W-1:0];
                end
            end else if (paddr_i == OFS_MASK) begin
                rv[ST_W-1:0] = q.mask;
                if (pwrite_i) begin
                    d.mask = pwdata_i[ST_W-1:0];
                end
            end else if (paddr_i == OFS_COUNT) begin
                rv[CNT_W-1:0] = q.cnt;
                rv[BUSY_BIT] = q.st != SQ_IDLE;
            end else if (paddr_i == OFS_LEVEL) begin
                for (int k = 0; k < NUM_FIFO; k++) begin
                    rv[k*LVL_STRIDE +: LVL_W] = q.lvl[k];
                end
            end else if (paddr_i[ADDR_W-1:5] == OFS_CMP[ADDR_W-1:5]) begin
                rv[CNT_W-1:0] = q.cmp[ri];
                if (pwrite_i) begin
                    d.cmp[ri] = pwdata_i[CNT_W-1:0];
                end
            end else if (paddr_i[ADDR_W-1:5] == OFS_TCFG[ADDR_W-1:5]) begin
                rv[TCFG_W-1:0] = q.tcfg[ri];
                if (pwrite_i) begin
                    d.tcfg[ri] = pwdata_i[TCFG_W-1:0];
                end
            end else if (paddr_i[ADDR_W-1:4] == OFS_FIFO[ADDR_W-1:4]) begin
                if (q.avail) begin
                    rv[RES_W:0] = fifo_bus.rdata;
                    rv[VALID_BIT] = 1'b1;
                    pop = !pwrite_i;
                end
            end else if (paddr_i[ADDR_W-1:7] == OFS_CMD[ADDR_W-1:7] &&
                         int'(paddr_i[CMD_AW+1:2]) < CMD_DEPTH) begin
                cmd_bus.we = pwrite_i;
            end else begin
                d.err = 1'b1;
            end
            d.rdata = pwrite_i ? '0 : rv;
        end

        // result fifos
        if (push) begin
            if (int'(q.lvl[push_f]) == fifo_depth(int'(push_f))) begin
                st_set[ST_FOVF_BIT] = 1'b1;
                push = 1'b0;
            end else begin
                fifo_bus.we = 1'b1;
                fifo_bus.waddr = FIFO_AW'(fifo_base(int'(push_f))) + FIFO_AW'(q.wp[push_f]);
                fifo_bus.wdata = push_data;
            end
        end
        for (int k = 0; k < NUM_FIFO; k++) begin
            if (push && push_f == 2'(k)) begin
                d.wp[k] = (int'(q.wp[k]) == fifo_depth(k) - 1) ? '0 : q.wp[k] + 1'b1;
            end
            if (pop && fsel == 2'(k)) begin
                d.rp[k] = (int'(q.rp[k]) == fifo_depth(k) - 1) ? '0 : q.rp[k] + 1'b1;
            end
            d.lvl[k] = q.lvl[k] + LVL_W'(push && push_f == 2'(k)) - LVL_W'(pop && fsel == 2'(k));
        end

        // sticky status, a new event beats a clear in the same cycle
        d.status = (q.status & ~st_clr) | st_set;
        d.irq = |(d.status & d.mask);
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign prdata_o = q.rdata;
    assign pready_o = q.ready;
    assign pslverr_o = q.err;
    assign trig_o = q.trig;
    assign cmd_valid_o = q.cmd_v;
    assign cmd_chan_o = q.cur[CHAN_W-1:0];
    assign cmd_conv_o = q.cur[CMD_CONV_BIT];
    assign cmd_dual_o = q.cur[CMD_DUAL_BIT];
    assign irq_o = q.irq;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_launch;
        q.st == SQ_IDLE && |cmd_req && q.tcfg[lowest(cmd_req)][TC_CNT_LSB +: CMD_AW] != '0;
    endsequence
    sequence s_dual_done;
        q.st == SQ_WR0 && q.cur[CMD_DUAL_BIT];
    endsequence

    property p_edge_fall_only;
        q.edge_sel[1:0] == 2'b10 |-> hit[0] == $fell(q.s2[0]);
    endproperty
    a_edge_fall_only: assert property (p_edge_fall_only) else $error("fall-only input edge wrong");
    property p_reload;
        q.en && !q.mode && |(hit & q.src) |=> q.cnt == '0 && q.fired == '0;
    endproperty
    a_reload: assert property (p_reload) else $error("counter not reloaded");
    property p_cmp0;
        q.en && !q.mode && !reload && !q.fired[0] && q.cnt == q.cmp[0] && pulse_en[0] |=> trig_o[0];
    endproperty
    a_cmp0: assert property (p_cmp0) else $error("comparator 0 missed");
    property p_seq_reload;
        q.en && q.mode && hit[0] && q.src[0] |=> q.cnt == '0 && q.seq_idx == '0 && q.armed;
    endproperty
    a_seq_reload: assert property (p_seq_reload) else $error("sequential reload wrong");
    property p_launch;
        s_launch |-> ##3 (cmd_valid_o || q.status[ST_OVR_BIT]);
    endproperty
    a_launch: assert property (p_launch) else $error("command not issued");
    property p_cmd_fields;
        cmd_valid_o |-> cmd_chan_o == $past(cmd_bus.rdata[CHAN_W-1:0]);
    endproperty
    a_cmd_fields: assert property (p_cmd_fields) else $error("command channel wrong");
    property p_depth;
        q.lvl[0] <= 5'h10 && q.lvl[1] <= 5'h10 && q.lvl[2] <= 5'h04 && q.lvl[3] <= 5'h04;
    endproperty
    a_depth: assert property (p_depth) else $error("fifo level beyond depth");
    property p_dual;
        s_dual_done |=> q.st == SQ_WR1 && $stable(q.cur[CMD_FIFO_LSB +: 2]);
    endproperty
    a_dual: assert property (p_dual) else $error("second result lost");
    property p_period;
        int'(q.per_cnt) <= CMD_PER_PERIOD;
    endproperty
    a_period: assert property (p_period) else $error("too many commands in period");
    property p_wait;
        q.st == SQ_WAIT |=> !cmd_valid_o;
    endproperty
    a_wait: assert property (p_wait) else $error("command issued before completion");
    property p_irq;
        fire[0] && q.mask[0] |=> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");
    property p_overrun;
        |cmd_req && q.st != SQ_IDLE |=> q.status[ST_OVR_BIT];
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged");
    property p_pulse;
        trig_o != '0 |=> (trig_o & $past(trig_o)) == '0;
    endproperty
    a_pulse: assert property (p_pulse) else $error("trigger longer than one cycle");
endmodule : trigger_scheduler

// ==== verification/conv_model.sv ====
// Purpose: converter pair that answers scheduler commands
// Assumes: commands arrive as one-cycle strobes on ref_clk_i
// Notes: done pulses a fixed latency after each command
`timescale 1ns/1ps
module conv_model #(
    parameter int LAT = 4
) (
    input wire logic ref_clk_i,    // clock
    input wire logic cmd_valid_i,  // command strobe
    input wire logic [4:0] chan_i, // channel to sample
    input wire logic conv_i,       // converter select
    input wire logic dual_i,       // both converters
    output logic [1:0] done_o,     // done pulse per converter
    output logic [11:0] d0_o,      // converter 0 result
    output logic [11:0] d1_o       // converter 1 result
);
    int cnt_q = 0;
    logic [1:0] who_q = 2'h0;
    logic [4:0] ch_q = 5'h00;
    initial begin
        done_o = 2'h0;
        d0_o = 12'h000;
        d1_o = 12'h000;
    end
    ////////////////////////////////////////////////////////////////
    // result is channel plus a converter mark; data toggle outside done
    always @(posedge ref_clk_i) begin
        done_o <= 2'h0;
        d0_o <= (cnt_q == 1) ? {7'h08, ch_q} : ~d0_o;
        d1_o <= (cnt_q == 1) ? {7'h10, ch_q} : ~d1_o;
        if (cmd_valid_i) begin
            who_q <= dual_i ? 2'h3 : (conv_i ? 2'h2 : 2'h1);
            ch_q <= chan_i;
            cnt_q <= LAT;
        end else if (cnt_q > 1) begin
            cnt_q <= cnt_q - 1;
        end else if (cnt_q == 1) begin
            cnt_q <= 0;
            done_o <= who_q;
        end
    end
endmodule : conv_model

// ==== verification/trigger_scheduler_tb.sv ====
// Purpose: self-checking bench for the trigger scheduler
// Assumes: converter model on the far side, reload on event pin 0
// Notes: commands land in fifos 0 and 2
`timescale 1ns/1ps
module trigger_scheduler_tb import tsched_pkg::*;;
    logic ref_clk_i = 1'b0, rst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
    logic [11:0] paddr = 12'h000, d0, d1;
    logic [31:0] pwdata = 32'h0, r, prdata_o;
    logic [7:0] ev = 8'h00, trig_o;
    logic pready_o, pslverr_o, cmd_valid_o, cmd_conv_o, cmd_dual_o, irq_o;
    logic [4:0] cmd_chan_o;
    logic [1:0] done;
    wire [8:0] v = {cmd_valid_o, trig_o};
    int bad_count = 0, n_checks = 0, cyc = 0;
    trigger_scheduler i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .event_i(ev), .conv_done_i(done), .conv0_data_i(d0), .conv1_data_i(d1),
        .trig_o(trig_o), .cmd_valid_o(cmd_valid_o), .cmd_chan_o(cmd_chan_o), .cmd_conv_o(cmd_conv_o),
        .cmd_dual_o(cmd_dual_o), .irq_o(irq_o));
    conv_model i_conv (.ref_clk_i(ref_clk_i), .cmd_valid_i(cmd_valid_o), .chan_i(cmd_chan_o),
        .conv_i(cmd_conv_o), .dual_i(cmd_dual_o), .done_o(done), .d0_o(d0), .d1_o(d1));
    ////////////////////////////////////////////////////////////////
    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        @(posedge ref_clk_i);
        while (pready_o !== 1'b1) @(posedge ref_clk_i);
        r = prdata_o;
        e = pslverr_o;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk_i);
    endtask : apb
    task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(r & m, x);
    endtask : rd
    // waits for a pulse on trigger i (8 is the command strobe), then checks it lasts one cycle
    task wait_pulse(input int i);
        int k;
        k = 0;
        @(negedge ref_clk_i);
        while (v[i] !== 1'b1 && k < 300) begin
            @(negedge ref_clk_i);
            k++;
        end
        chk({31'h0, v[i]}, 32'h1);
        @(negedge ref_clk_i);
        chk({31'h0, v[i]}, 32'h0);
        @(posedge ref_clk_i);
    endtask : wait_pulse
    ////////////////////////////////////////////////////////////////
    initial forever #10 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            wrap_up;
        end
    end
    initial begin
        repeat (10) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        rd(OFS_CTRL, 32'hffffffff, 32'h0);
        apb(1'b0, 12'h01c, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, OFS_EDGE, 32'h1);
        apb(1'b1, OFS_SRC, 32'h1);
        apb(1'b1, OFS_CMP, 32'h5);
        apb(1'b1, OFS_CMP + 12'h004, 32'h1e);
        apb(1'b1, OFS_TCFG, 32'h83);
        apb(1'b1, OFS_TCFG + 12'h004, 32'h86);
        apb(1'b1, OFS_CMD, 32'h3);
        apb(1'b1, OFS_CMD + 12'h004, 32'h145);
        apb(1'b1, OFS_MASK, 32'h1);
        apb(1'b1, OFS_CTRL, 32'h1);
        ev[0] <= 1'b1;
        wait_pulse(0);
        rd(OFS_STATUS, 32'h1, 32'h1);
        chk({31'h0, irq_o}, 32'h1);
        wait_pulse(8);
        chk({25'h0, cmd_dual_o, cmd_conv_o, cmd_chan_o}, 32'h45);
        rd(OFS_FIFO, 32'hffffffff, 32'h80000103);
        rd(OFS_LEVEL, 32'h1f0000, 32'h20000);
        rd(OFS_FIFO + 12'h008, 32'hffffffff, 32'h80000105);
        rd(OFS_FIFO + 12'h008, 32'hffffffff, 32'h80001205);
        rd(OFS_FIFO + 12'h008, 32'hffffffff, 32'h0);
        $display("test triggered_commands done");
        apb(1'b1, OFS_STATUS, 32'h3ff);
        rd(OFS_STATUS, 32'h3ff, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        apb(1'b1, OFS_CMP + 12'h004, 32'h6);
        apb(1'b1, OFS_EDGE, 32'h2);
        ev[0] <= 1'b0;
        wait_pulse(0);
        rd(OFS_STATUS, 32'h100, 32'h100);
        $display("test falling_edge_overrun done");
        apb(1'b1, OFS_STATUS, 32'h3ff);
        apb(1'b1, OFS_EDGE, 32'h5);
        apb(1'b1, OFS_SRC, 32'h3);
        apb(1'b1, OFS_TCFG + 12'h004, 32'h1);
        apb(1'b1, OFS_CTRL, 32'h3);
        ev[1] <= 1'b1;
        wait_pulse(1);
        rd(OFS_STATUS, 32'h3, 32'h2);
        ev[0] <= 1'b1;
        wait_pulse(0);
        $display("test sequential_mode done");
        wrap_up;
    end
endmodule : trigger_scheduler_tb
